// ---- common/lpm_consts.svh ----
// Offsets, field positions, reset values and timing counts for lpm block
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define LPM_OFF_PWRCTL     12'h000
`define LPM_OFF_STATUS     12'h004
`define LPM_OFF_PORTS      12'h008
`define LPM_OFF_CTRL       12'h00C
`define LPM_BIT_IDLE       0
`define LPM_BIT_PDOWN      1
`define LPM_BIT_GF0        2
`define LPM_BIT_GF1        3
`define LPM_BIT_WLE        4
`define LPM_BIT_SMOD       7
`define LPM_PWRCTL_RST     8'h00
`define LPM_PWRCTL_WMASK   8'h9F
`define LPM_PORT_RST       8'hFF
`define LPM_OSC_SETTLE_MS  10
`define LPM_CLK_HZ         50000000
`endif

// ---- common/lpm_pkg.sv ----
// Types shared by the low power mode control block
package lpm_pkg;
	typedef enum logic [2:0]
	{
		LPM_RUN   = 3'b001,
		LPM_IDLE  = 3'b010,
		LPM_PDOWN = 3'b100
	} lpm_mode_t;
endpackage : lpm_pkg

// ---- common/lpm_mode_if.sv ----
// Mode state signals between the control core and pin mux
`timescale 1ns/1ns
interface lpm_mode_if;
	logic idle;
	logic pdown;
	modport ctrl
	(
		output idle,
		output pdown
	);
	modport pins
	(
		input idle,
		input pdown
	);
endinterface : lpm_mode_if

// ---- verilog/lpm_pin_mux.sv ----
// Pin state selection during idle and power-down
`timescale 1ns/1ns
module lpm_pin_mux
(
	lpm_mode_if.pins       mode,
	input  wire logic       ext_mem,
	input  wire logic [7:0] addr_hi,
	input  wire logic [7:0] port_hi_reg,
	input  wire logic       ale_run,
	input  wire logic       program_store_strobe_n_n_run,
	input  wire logic       pwm_a_run,
	input  wire logic       pwm_b_run,
	input  wire logic [7:0] ad_out_run,
	input  wire logic       ad_oe_run,
	output logic      [7:0] hi_out,
	output logic            ale,
	output logic            program_store_strobe_n_n,
	output logic            pwm_a,
	output logic            pwm_b,
	output logic      [7:0] ad_out,
	output logic            ad_oe
);
	wire lowp = mode.idle | mode.pdown;
	wire hi_addr_sel = ext_mem & ~mode.pdown;
	assign hi_out = hi_addr_sel ? addr_hi : port_hi_reg;
	assign ale    = mode.idle ? 1'b1 : (mode.pdown ? 1'b0 : ale_run);
	assign program_store_strobe_n_n = mode.idle ? 1'b1 : (mode.pdown ? 1'b0 : program_store_strobe_n_n_run);
	assign pwm_a  = lowp ? 1'b1 : pwm_a_run;
	assign pwm_b  = lowp ? 1'b1 : pwm_b_run;
	// Low port floats only when fetching externally
	assign ad_oe  = (lowp & ext_mem) ? 1'b0 : ad_oe_run;
	assign ad_out = ad_out_run;
endmodule : lpm_pin_mux

// ---- verilog/lpm_ctrl.sv ----
// Low power mode control: power control register, mode FSM, APB slave
// Operation
// - Idle halts CPU, stops and clears capture timer, other state kept.
// - Idle resets both pulse outputs and drives them high.
// - Idle abandons any running analog conversion.
// - Idle keeps timers 0/1, watchdog, serial ports, interrupts running.
// - Power-down request bit sets only while watchdog enable input high.
// - Instruction setting power-down is the last one executed.
// - Power-down stops oscillator, keeps RAM and register contents.
// - In power-down, port pins output their port register values.
// - Only hardware reset ends power-down; interrupts do not.
// - Reset ending power-down restores registers, leaves RAM unchanged.
// - External fetch power-down: high port shows port register data.
// - Port latch one drives pin high during power-down.
// - Power control register written only as a whole byte.
// - Strobes held 1 in idle, 0 in power-down.
// - External memory: low port floats; high port address in idle.
// - Setting sleep request bit 0 enters idle.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "lpm_consts.svh"
module lpm_ctrl
(
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic             PREADY,
	output logic      [31:0] PRDATA,
	output logic             PSLVERR,
	input  wire logic        WDOG_EN,
	input  wire logic        IRQ_PEND,
	input  wire logic        EXT_MEM,
	input  wire logic [7:0]  ADDR_HI,
	input  wire logic        ALE_RUN,
	input  wire logic        PROGRAM_STORE_STROBE_N_N_RUN,
	input  wire logic        PWM_A_RUN,
	input  wire logic        PWM_B_RUN,
	input  wire logic [7:0]  AD_OUT_RUN,
	input  wire logic        AD_OE_RUN,
	input  wire logic        ADC_BUSY,
	output logic             CPU_HALT,
	output logic             CAPT_TIMER_RST,
	output logic             ADC_ABORT,
	output logic             KEEP_ALIVE_EN,
	output logic             OSC_STOP,
	output logic             PERIPH_RST,
	output logic      [7:0]  HI_PORT_OUT,
	output logic      [7:0]  HI_PORT_OE,
	output logic      [7:0]  AD_OUT,
	output logic      [7:0]  AD_OE,
	output logic             ALE,
	output logic             PROGRAM_STORE_STROBE_N,
	output logic             PULSE_OUT_A,
	output logic             PULSE_OUT_B,
	output logic             SMOD_OUT,
	output logic             WLE_OUT
);
	lpm_pkg::lpm_mode_t state_r;
	lpm_pkg::lpm_mode_t state_nxt;
	logic [7:0] pwrctl_r;
	logic [7:0] pwrctl_nxt;
	logic [7:0] port_hi_r;
	logic       adc_busy_r;
	logic       abort_r;
	lpm_mode_if mode_if ();

	function automatic logic [7:0] lane0(input logic [31:0] d);
		lane0 = d[7:0];
	endfunction : lane0

	wire acc       = PSEL & PENABLE;
	wire wr        = acc & PWRITE & PSTRB[0];
	wire sel_pwr   = PADDR == `LPM_OFF_PWRCTL;
	wire sel_stat  = PADDR == `LPM_OFF_STATUS;
	wire sel_port  = PADDR == `LPM_OFF_PORTS;
	wire sel_ctrl  = PADDR == `LPM_OFF_CTRL;
	wire mapped    = sel_pwr | sel_stat | sel_port | sel_ctrl;
	wire wr_pwr    = wr & sel_pwr;
	wire wr_port   = wr & sel_port;
	wire [7:0] wb  = lane0(PWDATA);
	// Whole byte only; no per-bit access path exists
	wire [7:0] wmask = `LPM_PWRCTL_WMASK;
	// Power-down bit refused when watchdog enable is low
	wire pd_ok     = wb[`LPM_BIT_PDOWN] & WDOG_EN;
	wire idl_req   = wr_pwr & wb[`LPM_BIT_IDLE];
	wire pd_req    = wr_pwr & pd_ok;
	wire in_idle   = state_r == lpm_pkg::LPM_IDLE;
	wire in_pdown  = state_r == lpm_pkg::LPM_PDOWN;
	wire idle_exit = in_idle & IRQ_PEND;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			lpm_pkg::LPM_RUN:
			begin
				if (pd_req)
					state_nxt = lpm_pkg::LPM_PDOWN;
				else if (idl_req)
					state_nxt = lpm_pkg::LPM_IDLE;
			end
			lpm_pkg::LPM_IDLE:
			begin
				if (idle_exit)
					state_nxt = lpm_pkg::LPM_RUN;
			end
			lpm_pkg::LPM_PDOWN:
			begin
				// Nothing but SYS_RST leaves this state
				state_nxt = lpm_pkg::LPM_PDOWN;
			end
			default:
				state_nxt = lpm_pkg::LPM_RUN;
		endcase
	end

	always_comb
	begin
		pwrctl_nxt = pwrctl_r;
		if (wr_pwr & ~in_pdown)
		begin
			pwrctl_nxt = wb & wmask;
			pwrctl_nxt[`LPM_BIT_PDOWN] = pd_ok;
		end
		if (idle_exit)
			pwrctl_nxt[`LPM_BIT_IDLE] = 1'b0;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			state_r    <= lpm_pkg::LPM_RUN;
			pwrctl_r   <= `LPM_PWRCTL_RST;
			port_hi_r  <= `LPM_PORT_RST;
			adc_busy_r <= 1'b0;
			abort_r    <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			pwrctl_r   <= pwrctl_nxt;
			if (wr_port & ~in_pdown)
				port_hi_r <= wb;
			adc_busy_r <= ADC_BUSY;
			// One pulse when idle begins over a running conversion
			abort_r    <= idl_req & ~pd_req & ADC_BUSY & ~in_idle;
		end
	end

	assign mode_if.idle  = in_idle;
	assign mode_if.pdown = in_pdown;

	lpm_pin_mux u_pins
	(
		.mode        (mode_if),
		.ext_mem     (EXT_MEM),
		.addr_hi     (ADDR_HI),
		.port_hi_reg (port_hi_r),
		.ale_run     (ALE_RUN),
		.program_store_strobe_n_n_run  (PROGRAM_STORE_STROBE_N_N_RUN),
		.pwm_a_run   (PWM_A_RUN),
		.pwm_b_run   (PWM_B_RUN),
		.ad_out_run  (AD_OUT_RUN),
		.ad_oe_run   (AD_OE_RUN),
		.hi_out      (HI_PORT_OUT),
		.ale         (ALE),
		.program_store_strobe_n_n      (PROGRAM_STORE_STROBE_N),
		.pwm_a       (PULSE_OUT_A),
		.pwm_b       (PULSE_OUT_B),
		.ad_out      (AD_OUT),
		.ad_oe       (AD_OE[0])
	);
	assign AD_OE[7:1] = {7{AD_OE[0]}};

	// High port is always driven; a one is a strong high in power-down
	assign HI_PORT_OE = 8'hFF;

	// Halt takes effect in the same cycle as the write, so no later
	// instruction completes before the low power state holds
	assign CPU_HALT       = in_idle | in_pdown | idl_req | pd_req;
	assign CAPT_TIMER_RST = in_idle;
	assign PERIPH_RST     = in_idle;
	assign ADC_ABORT      = abort_r | (in_idle & adc_busy_r);
	assign KEEP_ALIVE_EN  = ~in_pdown;
	// Stopping the oscillator freezes all state, RAM included
	assign OSC_STOP       = in_pdown;
	assign SMOD_OUT       = pwrctl_r[`LPM_BIT_SMOD];
	assign WLE_OUT        = pwrctl_r[`LPM_BIT_WLE];

	wire [31:0] status_w = {29'h0000000, ADC_BUSY, in_pdown, in_idle};
	wire [31:0] rd_mux =
		sel_pwr  ? {24'h000000, pwrctl_r} :
		sel_stat ? status_w :
		sel_port ? {24'h000000, port_hi_r} :
		sel_ctrl ? {31'h00000000, WDOG_EN} : 32'h00000000;

	assign PREADY  = 1'b1;
	assign PSLVERR = acc & ~mapped;
	assign PRDATA  = rd_mux;
endmodule : lpm_ctrl

// ---- tb/lpm_ctrl_monitor.sv ----
// Assertion checker for the low power mode control block
`timescale 1ns/1ns
module lpm_ctrl_monitor
(
	input wire logic        REF_CLK,
	input wire logic        SYS_RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0]  PSTRB,
	input wire logic        WDOG_EN,
	input wire logic        IRQ_PEND,
	input wire logic        EXT_MEM,
	input wire logic [7:0]  ADDR_HI,
	input wire logic        CAPT_TIMER_RST,
	input wire logic        OSC_STOP,
	input wire logic        CPU_HALT,
	input wire logic        ALE,
	input wire logic        PROGRAM_STORE_STROBE_N,
	input wire logic        PULSE_OUT_A,
	input wire logic        PULSE_OUT_B,
	input wire logic [7:0]  HI_PORT_OUT,
	input wire logic [7:0]  AD_OE
);
	wire wr = PSEL && PENABLE && PWRITE && PADDR == 12'h000 && PSTRB[0];
	wire run = !OSC_STOP && !IRQ_PEND;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	a_pd_wdog_gate:
	assert property (wr && PWDATA[1] && !WDOG_EN && run |=> !OSC_STOP)
		else $error("power-down taken without watchdog enable");
	a_idle_entry:
	assert property (wr && PWDATA[1:0] == 2'h1 && run |=> CAPT_TIMER_RST)
		else $error("idle not entered");
	a_both_pdown:
	assert property (wr && PWDATA[1:0] == 2'h3 && WDOG_EN && run
		|=> OSC_STOP && !CAPT_TIMER_RST) else $error("power-down lost");
	a_pd_sticky:
	assert property (OSC_STOP |=> OSC_STOP) else $error("power-down left");
	a_idle_strobes:
	assert property (CAPT_TIMER_RST |-> ALE && PROGRAM_STORE_STROBE_N
		&& CPU_HALT) else $error("idle strobes wrong");
	a_pd_strobes:
	assert property (OSC_STOP |-> !ALE && !PROGRAM_STORE_STROBE_N)
		else $error("power-down strobes wrong");
	a_pulse_high:
	assert property (CAPT_TIMER_RST || OSC_STOP |-> PULSE_OUT_A
		&& PULSE_OUT_B) else $error("pulse outputs not high");
	a_hi_addr:
	assert property (EXT_MEM && !OSC_STOP |-> HI_PORT_OUT == ADDR_HI)
		else $error("high port not address");
	a_ad_float:
	assert property (EXT_MEM && (CAPT_TIMER_RST || OSC_STOP)
		|-> AD_OE == 8'h00) else $error("low port driven");
	a_pd_port_hold:
	assert property (OSC_STOP && $past(OSC_STOP) |-> $stable(HI_PORT_OUT))
		else $error("port moved in power-down");
endmodule : lpm_ctrl_monitor
bind lpm_ctrl lpm_ctrl_monitor u_mon
(
	.REF_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
	.WDOG_EN, .IRQ_PEND, .EXT_MEM, .ADDR_HI, .CAPT_TIMER_RST, .OSC_STOP,
	.CPU_HALT, .ALE, .PROGRAM_STORE_STROBE_N, .PULSE_OUT_A, .PULSE_OUT_B,
	.HI_PORT_OUT, .AD_OE
);

// ---- tb/lpm_ctrl_bench.sv ----
// Self-checking bench for the low power mode control block
`timescale 1ns/1ns
module lpm_ctrl_bench;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        wdog = 1'h0;
	logic        irq = 1'h0;
	logic        ext = 1'h0;
	logic        rv = 1'h0;
	logic        busy = 1'h0;
	logic [31:0] rdat;
	logic        er;
	int          error_cnt = 0;
	int          checks_done = 0;
	wire         ready, slverr, halt, ctr, abort, alive, osc;
	wire         ale, program_store_strobe_n_n, pa, pb;
	wire  [31:0] prdata;
	wire  [7:0]  hi, hi_oe, ad_oe;
	lpm_ctrl u_dut
	(
		.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
		.PREADY(ready), .PRDATA(prdata), .PSLVERR(slverr),
		.WDOG_EN(wdog), .IRQ_PEND(irq), .EXT_MEM(ext), .ADDR_HI(8'h3C),
		.ALE_RUN(rv), .PROGRAM_STORE_STROBE_N_N_RUN(rv), .PWM_A_RUN(rv), .PWM_B_RUN(rv),
		.AD_OUT_RUN(8'hA5), .AD_OE_RUN({8{rv}}), .ADC_BUSY(busy),
		.CPU_HALT(halt), .CAPT_TIMER_RST(ctr), .ADC_ABORT(abort),
		.KEEP_ALIVE_EN(alive), .OSC_STOP(osc), .PERIPH_RST(),
		.HI_PORT_OUT(hi), .HI_PORT_OE(hi_oe), .AD_OUT(), .AD_OE(ad_oe),
		.ALE(ale), .PROGRAM_STORE_STROBE_N(program_store_strobe_n_n), .PULSE_OUT_A(pa),
		.PULSE_OUT_B(pb), .SMOD_OUT(), .WLE_OUT()
	);
	always #10 clk = ~clk;
	// Wide enough for a flag joined to a full data word
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		checks_done++;
		if (got !== exp)
			$display("Error at %0t: got %h want %h", $time, got, exp);
		if (got !== exp)
			error_cnt++;
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		// Ready and read data looked at mid-cycle, held through the edge
		@(negedge clk);
		while (ready !== 1'h1 && n < 20)
		begin
			n++;
			@(negedge clk);
		end
		rdat = prdata;
		er = slverr;
		@(posedge clk);
		if (n == 20)
			chk(32'h1, 32'h0);
		if (n == 20)
			report_and_stop;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : apb
	task automatic t_idle;
		apb(1'h0, 12'h008, 32'h0);
		chk(rdat, 32'hFF);
		apb(1'h0, 12'h010, 32'h0);
		chk({er, rdat}, 33'h100000000);
		ext <= 1'h1;
		busy <= 1'h1;
		apb(1'h1, 12'h000, 32'h1);
		@(negedge clk);
		chk({halt, ctr, osc, alive, abort}, 5'h1B);
		chk({pa, pb, ale, program_store_strobe_n_n}, 4'hF);
		chk({ad_oe, hi}, 16'h003C);
		@(posedge clk);
		irq <= 1'h1;
		repeat (10) if (ctr === 1'h1) @(posedge clk);
		@(negedge clk);
		chk(ctr, 1'h0);
		@(posedge clk);
		irq <= 1'h0;
		busy <= 1'h0;
		$display("idle test done");
	endtask : t_idle
	task automatic t_pdown;
		apb(1'h1, 12'h000, 32'h2);
		apb(1'h0, 12'h000, 32'h0);
		chk(rdat[1], 1'h0);
		apb(1'h1, 12'h008, 32'h5A);
		wdog <= 1'h1;
		apb(1'h1, 12'h000, 32'h3);
		@(negedge clk);
		chk({osc, ctr, halt, ale, program_store_strobe_n_n, pa, pb}, 7'h53);
		chk({hi, hi_oe, ad_oe}, 24'h5AFF00);
		@(posedge clk);
		irq <= 1'h1;
		apb(1'h1, 12'h000, 32'h0);
		@(negedge clk);
		chk({osc, hi}, 9'h15A);
		@(posedge clk);
		rst <= 1'h1;
		irq <= 1'h0;
		// Two edges so the checker sees reset before it lifts
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		apb(1'h0, 12'h008, 32'h0);
		chk({osc, rdat}, 33'hFF);
		$display("power-down test done");
	endtask : t_pdown
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		t_idle;
		t_pdown;
		report_and_stop;
	end
endmodule : lpm_ctrl_bench
